// ==== stp_pkg.sv ====
// Shared constants and types for the scan test access port
package stp_pkg;

   // Controller states of the sixteen-state test access port graph
   typedef enum logic [3:0] {
      ST_TLR,
      ST_RTI,
      ST_SEL_DR,
      ST_CAP_DR,
      ST_SH_DR,
      ST_EX1_DR,
      ST_PAU_DR,
      ST_EX2_DR,
      ST_UPD_DR,
      ST_SEL_IR,
      ST_CAP_IR,
      ST_SH_IR,
      ST_EX1_IR,
      ST_PAU_IR,
      ST_EX2_IR,
      ST_UPD_IR
   } stp_state_e;

   // Instruction register layout
   localparam int          STP_IR_W       = 8;
   localparam logic [7:0]  STP_IR_CAPTURE = 8'h81;
   localparam logic [7:0]  STP_IR_BYPASS  = 8'hFF;
   localparam logic [7:0]  STP_IR_RESET   = 8'hFF;

   // Default width of the sample/update data register
   localparam int          STP_DR_W       = 8;

   // Reset and capture values
   localparam logic        STP_BYP_CAPTURE = 1'b0;
   localparam logic        STP_TDO_RESET   = 1'b0;
   localparam logic        STP_OE_N_RESET  = 1'b1;

   // Five consecutive high mode-select samples always reach the reset state
   localparam int          STP_TLR_ONES    = 5;

endpackage

// ==== stp_tap.sv ====
// Boundary-scan test access port: state machine, instruction and data registers, crossing to system clock
`timescale 1ns/100ps
//
// Functional notes
// - All scan logic runs from the test clock alone, no other clock touches scan state.
// - Mode select, serial data and normal-function inputs are sampled on the rising test clock edge.
// - Serial output and normal-function outputs change only on the falling test clock edge.
// - Leaving Capture-IR loads the 8-bit instruction shifter with 10000001.
// - In Shift-IR and Shift-DR one bit moves from serial input toward serial output per rising edge.
// - The serial output driver turns on at the falling edge after entering a shift state.
// - The last bit is still shifted on the rising edge that moves from a shift state to Exit1.
// - In Exit1-IR and Exit1-DR the serial output returns to high impedance at the falling edge.
// - The instruction is adopted at the falling edge in Update-IR, and all ones selects bypass.
// - With bypass selected the one-bit bypass register loads 0 on leaving Capture-DR.
// - With bypass selected serial input reaches serial output through exactly one stage.
// - The selected data register takes its shifted contents at the falling edge in Update-DR.
// - From Test-Logic-Reset a low mode select moves the controller to Run-Test/Idle.
module stp_tap
   import stp_pkg::*;
#(
   parameter int DR_W = STP_DR_W
) (
   input  wire logic            ref_clk_in,
   input  wire logic            reset_n_in,
   input  wire logic            tck_in,
   input  wire logic            tms_in,
   input  wire logic            tdi_in,
   input  wire logic [DR_W-1:0] sample_in,
   output logic                 tdo_out,
   output logic                 tdo_oe_n_out,
   output logic [DR_W-1:0]      pattern_out,
   output logic [DR_W-1:0]      ref_data_out,
   output logic                 ref_update_out,
   output logic                 ref_bypass_out
);

   ////////////////////////////////////////////////////////////////////////////
   // Decoding helpers

   function automatic stp_state_e next_state(input stp_state_e s, input logic tms);
      stp_state_e n;
      n = ST_TLR;
      case (s)
         ST_TLR:    n = tms ? ST_TLR    : ST_RTI;
         ST_RTI:    n = tms ? ST_SEL_DR : ST_RTI;
         ST_SEL_DR: n = tms ? ST_SEL_IR : ST_CAP_DR;
         ST_CAP_DR: n = tms ? ST_EX1_DR : ST_SH_DR;
         ST_SH_DR:  n = tms ? ST_EX1_DR : ST_SH_DR;
         ST_EX1_DR: n = tms ? ST_UPD_DR : ST_PAU_DR;
         ST_PAU_DR: n = tms ? ST_EX2_DR : ST_PAU_DR;
         ST_EX2_DR: n = tms ? ST_UPD_DR : ST_SH_DR;
         ST_UPD_DR: n = tms ? ST_SEL_DR : ST_RTI;
         ST_SEL_IR: n = tms ? ST_TLR    : ST_CAP_IR;
         ST_CAP_IR: n = tms ? ST_EX1_IR : ST_SH_IR;
         ST_SH_IR:  n = tms ? ST_EX1_IR : ST_SH_IR;
         ST_EX1_IR: n = tms ? ST_UPD_IR : ST_PAU_IR;
         ST_PAU_IR: n = tms ? ST_EX2_IR : ST_PAU_IR;
         ST_EX2_IR: n = tms ? ST_UPD_IR : ST_SH_IR;
         ST_UPD_IR: n = tms ? ST_SEL_DR : ST_RTI;
         default:   n = ST_TLR;
      endcase
      return n;
   endfunction

   function automatic logic is_shift(input stp_state_e s);
      return (s == ST_SH_IR) || (s == ST_SH_DR);
   endfunction

   function automatic logic is_bypass(input logic [STP_IR_W-1:0] op);
      return op == STP_IR_BYPASS;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Test clock domain: reset synchroniser and input sampling

   // Reset must reach the scan logic on the test clock; it forces Test-Logic-Reset
   logic            rst_meta_reg;
   logic            rst_sync_reg;
   logic            tap_rst;
   logic [DR_W-1:0] sample_meta_reg;
   logic [DR_W-1:0] sample_sync_reg;

   always_ff @(posedge tck_in) begin
      rst_meta_reg <= reset_n_in;
      rst_sync_reg <= rst_meta_reg;
   end

   assign tap_rst = ~rst_sync_reg;

   // Pins are asynchronous to the test clock, so two stages before capture
   always_ff @(posedge tck_in) begin
      sample_meta_reg <= sample_in;
      sample_sync_reg <= sample_meta_reg;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Controller state machine

   stp_state_e state_reg;
   stp_state_e state_next;

   always_comb begin
      state_next = next_state(state_reg, tms_in);
   end

   always_ff @(posedge tck_in) begin
      if (tap_rst) begin
         state_reg <= ST_TLR;
      end else begin
         state_reg <= state_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Instruction register

   logic [STP_IR_W-1:0] ir_shift_reg;
   logic [STP_IR_W-1:0] ir_reg;
   logic                ir_byp_reg;
   logic                bypass_sel;

   always_ff @(posedge tck_in) begin
      if (tap_rst) begin
         ir_shift_reg <= STP_IR_CAPTURE;
      end else if (state_reg == ST_CAP_IR) begin
         ir_shift_reg <= STP_IR_CAPTURE;
      end else if (state_reg == ST_SH_IR) begin
         // Includes the exit edge, so the last bit is not dropped
         ir_shift_reg <= {tdi_in, ir_shift_reg[STP_IR_W-1:1]};
      end
   end

   // Falling edge update keeps the active instruction steady across the rising edge
   // Bypass decode registered, so the system side never synchronises a decode glitch
   always_ff @(negedge tck_in) begin
      if (tap_rst || state_reg == ST_TLR) begin
         ir_reg     <= STP_IR_RESET;
         ir_byp_reg <= is_bypass(STP_IR_RESET);
      end else if (state_reg == ST_UPD_IR) begin
         ir_reg     <= ir_shift_reg;
         ir_byp_reg <= is_bypass(ir_shift_reg);
      end
   end

   assign bypass_sel = ir_byp_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Data registers: bypass and sample/update

   logic            byp_reg;
   logic [DR_W-1:0] dr_shift_reg;
   logic [DR_W-1:0] dr_upd_reg;
   logic            upd_tgl_reg;

   always_ff @(posedge tck_in) begin
      if (tap_rst) begin
         byp_reg <= STP_BYP_CAPTURE;
      end else if (state_reg == ST_CAP_DR) begin
         byp_reg <= STP_BYP_CAPTURE;
      end else if (state_reg == ST_SH_DR) begin
         byp_reg <= tdi_in;
      end
   end

   always_ff @(posedge tck_in) begin
      if (tap_rst) begin
         dr_shift_reg <= '0;
      end else if (state_reg == ST_CAP_DR && !bypass_sel) begin
         dr_shift_reg <= sample_sync_reg;
      end else if (state_reg == ST_SH_DR && !bypass_sel) begin
         dr_shift_reg <= {tdi_in, dr_shift_reg[DR_W-1:1]};
      end
   end

   // Update and pattern launch on the falling edge; toggle tells the system side
   always_ff @(negedge tck_in) begin
      if (tap_rst) begin
         dr_upd_reg  <= '0;
         upd_tgl_reg <= 1'b0;
      end else if (state_reg == ST_UPD_DR && !bypass_sel) begin
         dr_upd_reg  <= dr_shift_reg;
         upd_tgl_reg <= ~upd_tgl_reg;
      end
   end

   assign pattern_out = dr_upd_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Serial output driver

   logic tdo_reg;
   logic tdo_oe_n_reg;

   always_ff @(negedge tck_in) begin
      if (tap_rst) begin
         tdo_reg      <= STP_TDO_RESET;
         tdo_oe_n_reg <= STP_OE_N_RESET;
      end else begin
         // Enabled only in shift states; Exit1 and all others float the pin
         tdo_oe_n_reg <= ~is_shift(state_reg);
         if (state_reg == ST_SH_IR) begin
            tdo_reg <= ir_shift_reg[0];
         end else if (state_reg == ST_SH_DR) begin
            tdo_reg <= bypass_sel ? byp_reg : dr_shift_reg[0];
         end
      end
   end

   assign tdo_out      = tdo_reg;
   assign tdo_oe_n_out = tdo_oe_n_reg;

   ////////////////////////////////////////////////////////////////////////////
   // System clock domain: update word and bypass level

   // The update word is held steady for many test clock cycles after the toggle,
   // so it is safe to sample once the toggle has been synchronised
   logic            tgl_meta_reg;
   logic            tgl_sync_reg;
   logic            tgl_seen_reg;
   logic            byp_meta_reg;
   logic            byp_sync_reg;
   logic [DR_W-1:0] ref_data_reg;
   logic            ref_update_reg;
   logic            tgl_event;

   always_ff @(posedge ref_clk_in) begin
      tgl_meta_reg <= upd_tgl_reg;
      tgl_sync_reg <= tgl_meta_reg;
      byp_meta_reg <= bypass_sel;
      byp_sync_reg <= byp_meta_reg;
   end

   assign tgl_event = tgl_sync_reg ^ tgl_seen_reg;

   always_ff @(posedge ref_clk_in) begin
      if (!reset_n_in) begin
         tgl_seen_reg   <= 1'b0;
         ref_data_reg   <= '0;
         ref_update_reg <= 1'b0;
      end else begin
         tgl_seen_reg   <= tgl_sync_reg;
         ref_update_reg <= tgl_event;
         if (tgl_event) begin
            ref_data_reg <= dr_upd_reg;
         end
      end
   end

   assign ref_data_out   = ref_data_reg;
   assign ref_update_out = ref_update_reg;
   assign ref_bypass_out = byp_sync_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Assertions

   a_ir_capture: assert property (@(posedge tck_in) disable iff (tap_rst)
      state_reg == ST_CAP_IR |=> ir_shift_reg == STP_IR_CAPTURE)
      else $error("IR shifter did not capture 10000001");

   a_ir_lastbit: assert property (@(posedge tck_in) disable iff (tap_rst)
      (state_reg == ST_SH_IR && tms_in) |=> (state_reg == ST_EX1_IR) && ir_shift_reg[7] == $past(tdi_in))
      else $error("Last IR bit lost on exit from Shift-IR");

   a_dr_shift: assert property (@(posedge tck_in) disable iff (tap_rst)
      (state_reg == ST_SH_DR && !bypass_sel)
      |=> dr_shift_reg == {$past(tdi_in), $past(dr_shift_reg[DR_W-1:1])})
      else $error("Data register did not move one bit per edge");

   a_dr_capture: assert property (@(posedge tck_in) disable iff (tap_rst)
      (state_reg == ST_CAP_DR && !bypass_sel) |=> dr_shift_reg == $past(sample_sync_reg))
      else $error("Data register did not capture the sampled inputs");

   // The falling edge inside a state is launched from that state, seen at the next rising edge
   a_tdo_enable: assert property (@(posedge tck_in) disable iff (tap_rst)
      is_shift(state_reg) |-> !tdo_oe_n_reg)
      else $error("Serial output not driven after entering shift");

   a_tdo_hiz: assert property (@(posedge tck_in) disable iff (tap_rst)
      (state_reg == ST_EX1_IR || state_reg == ST_EX1_DR) |-> tdo_oe_n_reg)
      else $error("Serial output not released in Exit1");

   a_tdo_float: assert property (@(posedge tck_in) disable iff (tap_rst)
      !is_shift(state_reg) |-> tdo_oe_n_reg)
      else $error("Serial output driven outside a shift state");

   a_tdo_ir_bit: assert property (@(posedge tck_in) disable iff (tap_rst)
      state_reg == ST_SH_IR |-> tdo_reg == ir_shift_reg[0])
      else $error("Serial output does not show the next IR bit");

   a_tdo_dr_bit: assert property (@(posedge tck_in) disable iff (tap_rst)
      (state_reg == ST_SH_DR && !bypass_sel) |-> tdo_reg == dr_shift_reg[0])
      else $error("Serial output does not show the next data bit");

   a_ir_update: assert property (@(posedge tck_in) disable iff (tap_rst)
      state_reg == ST_UPD_IR |=> ir_reg == $past(ir_shift_reg) && (bypass_sel == (ir_reg == 8'hFF)))
      else $error("Instruction not adopted in Update-IR");

   a_byp_capture: assert property (@(posedge tck_in) disable iff (tap_rst)
      (state_reg == ST_CAP_DR && bypass_sel) |=> byp_reg == 1'b0)
      else $error("Bypass register did not capture zero");

   a_byp_delay: assert property (@(posedge tck_in) disable iff (tap_rst)
      (state_reg == ST_SH_DR && bypass_sel) ##1 (state_reg == ST_SH_DR) |-> tdo_reg == $past(tdi_in))
      else $error("Bypass path is not one stage");

   a_dr_update: assert property (@(posedge tck_in) disable iff (tap_rst)
      (state_reg == ST_UPD_DR && !bypass_sel) |=> pattern_out == $past(dr_shift_reg))
      else $error("Data register not updated in Update-DR");

   a_tlr_leave: assert property (@(posedge tck_in) disable iff (tap_rst)
      (state_reg == ST_TLR && !tms_in) |=> state_reg == ST_RTI)
      else $error("Test-Logic-Reset did not advance on low mode select");

   a_tms_ones: assert property (@(posedge tck_in) disable iff (tap_rst)
      tms_in [*5] |=> state_reg == ST_TLR)
      else $error("Five high mode selects did not reach reset state");

   a_ir_reset: assert property (@(posedge tck_in) disable iff (tap_rst)
      state_reg == ST_TLR |-> bypass_sel && ir_reg == STP_IR_RESET)
      else $error("Reset state did not select bypass");

   a_pattern_hold: assert property (@(posedge tck_in) disable iff (tap_rst)
      state_reg != ST_UPD_DR |-> $stable(pattern_out))
      else $error("Normal-function outputs changed outside Update-DR");

   a_ref_word: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
      ref_update_reg |-> ref_data_reg == dr_upd_reg)
      else $error("System copy of update word is stale");

   c_ir_scan: cover property (@(posedge tck_in) disable iff (tap_rst)
      state_reg == ST_UPD_IR ##1 bypass_sel);

   c_bypass_shift: cover property (@(posedge tck_in) disable iff (tap_rst)
      (state_reg == ST_SH_DR && bypass_sel) [*3]);

   c_dr_update: cover property (@(posedge tck_in) disable iff (tap_rst)
      state_reg == ST_UPD_DR && !bypass_sel);

   c_ref_update: cover property (@(posedge ref_clk_in) disable iff (!reset_n_in)
      ref_update_reg);

   c_tlr_return: cover property (@(posedge tck_in) disable iff (tap_rst)
      state_reg == ST_SEL_IR && tms_in);

endmodule

// ==== stp_ctl_model.sv ====
// Behavioural test controller that drives the four-wire scan link
`timescale 1ns/100ps
module stp_ctl_model (
   output logic      tck_out,
   output logic      tms_out,
   output logic      tdi_out,
   input  wire logic tdo_in,
   input  wire logic tdo_oe_n_in
);
   // Clock rests low between frames
   initial begin
      tck_out = 1'b0;
      tms_out = 1'b1;
      tdi_out = 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // One link cycle; gap stretches the low phase to act as a slow controller
   task automatic step(input logic m, input logic d, input int gap, output logic q, output logic oe_n);
      tms_out = m;
      tdi_out = d;
      #(5 + gap);
      tck_out = 1'b1;
      #6;
      tck_out = 1'b0;
      #1;
      // Nothing holds a released line; the inverse makes a stray read fail
      q    = tdo_oe_n_in ? ~tdo_in : tdo_in;
      oe_n = tdo_oe_n_in;
   endtask
endmodule

// ==== scan_tap_sequencing_tb.sv ====
// Self-checking bench for the scan test access port
`timescale 1ns/100ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin num_errors++; \
   $display("ERROR %s expected %h seen %h", nm, e, g); end end
module scan_tap_sequencing_tb;
   import stp_pkg::*;
   localparam int DR_W = STP_DR_W;
   logic            ref_clk    = 1'b0;
   logic            reset_n    = 1'b0;
   logic [DR_W-1:0] sample     = '0;
   logic            tck;
   logic            tms;
   logic            tdi;
   logic            tdo;
   logic            tdo_oe_n;
   logic            ref_update;
   logic            ref_bypass;
   logic [DR_W-1:0] pattern;
   logic [DR_W-1:0] ref_data;
   logic            q;
   logic            oe;
   logic [15:0]     dout;
   int              num_errors = 0;
   int              num_checks = 0;
   int              cycles     = 0;

   always #2.5 ref_clk = ~ref_clk;

   stp_tap #(.DR_W(DR_W)) dut (
      .ref_clk_in    (ref_clk),
      .reset_n_in    (reset_n),
      .tck_in        (tck),
      .tms_in        (tms),
      .tdi_in        (tdi),
      .sample_in     (sample),
      .tdo_out       (tdo),
      .tdo_oe_n_out  (tdo_oe_n),
      .pattern_out   (pattern),
      .ref_data_out  (ref_data),
      .ref_update_out(ref_update),
      .ref_bypass_out(ref_bypass)
   );

   stp_ctl_model ctl (
      .tck_out    (tck),
      .tms_out    (tms),
      .tdi_out    (tdi),
      .tdo_in     (tdo),
      .tdo_oe_n_in(tdo_oe_n)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Outside shifts tdi carries no meaning, so it toggles
   task automatic go(input logic m);
      ctl.step(m, tdi !== 1'b1, 0, q, oe);
   endtask

   // From Run-Test/Idle or Update to the Update state of an IR or DR scan
   task automatic scan(input logic ir, input int len, input logic [15:0] din, input int gap);
      dout = '0;
      go(1'b1);
      if (ir) go(1'b1);
      go(1'b0);
      go(1'b0);
      dout[0] = q;
      `CHK("oe_n shift entry", 1'b0, oe)
      for (int i = 0; i < len; i++) begin
         ctl.step(i == len - 1, din[i], gap, q, oe);
         if (i < len - 1) begin
            dout[i+1] = q;
            `CHK("oe_n shifting", 1'b0, oe)
         end
      end
      `CHK("oe_n exit1", 1'b1, oe)
      go(1'b1);
   endtask

   task automatic ref_wait(input logic [DR_W-1:0] exp);
      int n;
      n = 0;
      while (ref_update !== 1'b1 && n < 10) begin
         @(posedge ref_clk);
         #1;
         n++;
      end
      `CHK("ref_data", exp, ref_data)
      @(posedge ref_clk);
      #1;
      `CHK("ref_update pulse end", 1'b0, ref_update)
   endtask

   task automatic give_verdict();
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      `CHK("oe_n reset", 1'b1, tdo_oe_n)
      `CHK("pattern reset", '0, pattern)
      `CHK("bypass reset", 1'b1, ref_bypass)
      $display("test reset done");
   endtask

   // Capture pattern out LSB first, non-bypass opcode adopted
   task automatic t_ir_capture();
      go(1'b0);
      scan(1'b1, 8, 16'h0000, 0);
      `CHK("ir capture", 8'h81, dout[7:0])
      go(1'b0);
      repeat (5) @(posedge ref_clk);
      #1;
      `CHK("bypass off", 1'b0, ref_bypass)
      $display("test ir capture done");
   endtask

   // Back-to-back data scans, the second from a slow controller
   task automatic t_dr_update();
      @(negedge ref_clk) sample = 8'h3C;
      scan(1'b0, DR_W, 16'h00A5, 0);
      `CHK("dr capture", 8'h3C, dout[7:0])
      `CHK("pattern update", 8'hA5, pattern)
      ref_wait(8'hA5);
      scan(1'b0, DR_W, 16'h005A, 7);
      `CHK("dr capture slow", 8'h3C, dout[7:0])
      `CHK("pattern slow", 8'h5A, pattern)
      ref_wait(8'h5A);
      $display("test dr update done");
   endtask

   // Bypass: one-stage delay, captured zero, no data register update
   task automatic t_bypass();
      scan(1'b1, 8, 16'h00FF, 0);
      go(1'b0);
      repeat (5) @(posedge ref_clk);
      #1;
      `CHK("bypass on", 1'b1, ref_bypass)
      scan(1'b0, 3, 16'h0005, 0);
      `CHK("bypass stream", 3'b010, dout[2:0])
      `CHK("pattern kept", 8'h5A, pattern)
      repeat (5) go(1'b1);
      go(1'b0);
      scan(1'b1, 8, 16'h0003, 0);
      `CHK("ir after tlr", 8'h81, dout[7:0])
      $display("test bypass done");
   endtask

   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 20000) begin
         num_errors++;
         give_verdict();
      end
   end

   initial begin
      repeat (4) go(1'b1);
      @(negedge ref_clk) reset_n = 1'b1;
      repeat (3) go(1'b1);
      t_reset();
      t_ir_capture();
      t_dr_update();
      t_bypass();
      give_verdict();
   end
endmodule
